/* File: include/acc_if.sv */
// Two-wire link between the target port and a bus master.
// Both lines are open drain with pull-ups resolved here.
`timescale 1ns/100ps
`default_nettype none
interface acc_if;
   logic scl_oe_m;
   logic sda_oe_m;
   logic sda_oe_t;
   logic scl;
   logic sda;
   // Pull-ups: a line is low only while someone drives it
   assign scl = ~scl_oe_m;
   assign sda = ~(sda_oe_m | sda_oe_t);
   modport target (input scl, input sda, output sda_oe_t);
   modport master (input scl, input sda, output scl_oe_m, output sda_oe_m);
endinterface
`default_nettype wire

/* File: include/acc_pkg.sv */
// Package for the two-wire target port and its bus master.
// Assumes a single 250 MHz system clock at both ends.
package acc_pkg;
   localparam int          SYS_CLK_HZ       = 250_000_000;
   localparam int          SCL_STD_HZ       = 100_000;
   localparam int          SCL_FAST_HZ      = 400_000;
   // Half period of the generated bus clock, fast mode
   localparam int          SCL_HALF_CYC     = SYS_CLK_HZ / (2 * SCL_FAST_HZ);
   localparam logic [6:0]  ADDR_SEL_HIGH    = 7'h1D;
   localparam logic [6:0]  ADDR_SEL_LOW     = 7'h53;
   localparam logic [7:0]  REG_PTR_RESET    = 8'h00;
   localparam logic [2:0]  BIT_MSB          = 3'h7;
   localparam int          REG_DEPTH        = 64;
   localparam logic        DIR_WRITE        = 1'b0;
   localparam logic        DIR_READ         = 1'b1;

   typedef enum logic [2:0] {
      TGT_IDLE  = 3'b000,
      TGT_ADDR  = 3'b001,
      TGT_ACK   = 3'b010,
      TGT_RX    = 3'b011,
      TGT_TX    = 3'b100,
      TGT_MACK  = 3'b101
   } acc_tgt_state_e;

   typedef enum logic [3:0] {
      MST_IDLE  = 4'b0000,
      MST_START = 4'b0001,
      MST_BIT   = 4'b0010,
      MST_ACK   = 4'b0011,
      MST_STOP  = 4'b0100,
      MST_RSTRT = 4'b0101,
      MST_DONE  = 4'b0110
   } acc_mst_state_e;
endpackage

/* File: rtl/acc_master.sv */
// Bus master: one write or one read burst per request, fast-mode clock.
// Assumes the target may not stretch the clock.
`timescale 1ns/100ps
`default_nettype none
module acc_master #(
   parameter int HALF = acc_pkg::SCL_HALF_CYC
) (
   input  wire logic       sys_clk_i,
   input  wire logic       rst_n_i,
   acc_if.master           bus,
   input  wire logic       req_i,
   input  wire logic       rd_i,
   input  wire logic [6:0] taddr_i,
   input  wire logic [7:0] reg_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic [3:0] len_i,
   output logic            busy_o,
   output logic [7:0]      rdata_o,
   output logic            rvalid_o,
   output logic            nack_o
);
   import acc_pkg::*;

   initial begin
      if (HALF < 2 || HALF > 65535) $error("HALF out of range");
   end

   acc_mst_state_e st_q, st_d;
   logic [15:0] tm_q, tm_d;
   logic        ph_q, ph_d, scl_q, scl_d, sda_q, sda_d;
   logic [7:0]  sh_q, sh_d, rd_q, rd_d;
   logic [3:0]  bit_q, bit_d, len_q, len_d;
   logic [1:0]  byt_q, byt_d;
   logic        rw_q, rw_d, rv_q, rv_d, nk_q, nk_d, rx_q, rx_d;
   logic [6:0]  ta_q, ta_d;
   logic [7:0]  ra_q, ra_d, wd_q, wd_d;
   logic [1:0]  sda_s_q, sda_s_d;
   logic        tick;

   assign tick = (tm_q == 16'(HALF - 1));

   always_comb begin
      sda_s_d = {sda_s_q[0], bus.sda};
      st_d = st_q; tm_d = tick ? 16'h0000 : tm_q + 16'h0001;
      ph_d = ph_q; scl_d = scl_q; sda_d = sda_q; sh_d = sh_q; rd_d = rd_q;
      bit_d = bit_q; len_d = len_q; byt_d = byt_q; rw_d = rw_q;
      rv_d = 1'b0; nk_d = nk_q; rx_d = rx_q; ta_d = ta_q; ra_d = ra_q; wd_d = wd_q;
      case (st_q)
         MST_IDLE: begin
            tm_d = 16'h0000;
            if (req_i) begin
               rw_d = rd_i; ta_d = taddr_i; ra_d = reg_i; wd_d = wdata_i;
               len_d = len_i; nk_d = 1'b0; byt_d = 2'h0; rx_d = 1'b0;
               sh_d = {taddr_i, DIR_WRITE}; sda_d = 1'b0;
               st_d = MST_START;
            end
         end
         // Restart: clock up with data released, then data falls with clock high
         MST_RSTRT: if (tick) begin
            ph_d = ~ph_q;
            if (!ph_q) scl_d = 1'b1;
            else begin
               sda_d = 1'b0;
               st_d = MST_START;
            end
         end
         MST_START: if (tick) begin
            scl_d = 1'b0; sda_d = sh_q[7]; bit_d = 4'h0; ph_d = 1'b0;
            st_d = MST_BIT;
         end
         MST_BIT, MST_ACK: if (tick) begin
            ph_d = ~ph_q;
            if (!ph_q) scl_d = 1'b1;
            else begin
               scl_d = 1'b0;
               if (st_q == MST_BIT) begin
                  sh_d = {sh_q[6:0], sda_s_q[1]};
                  if (bit_q == 4'h7) begin
                     st_d = MST_ACK;
                     // Read data: ack unless last byte
                     sda_d = rx_q ? (len_q == 4'h1) : 1'b1;
                     if (rx_q) begin
                        rd_d = {sh_q[6:0], sda_s_q[1]};
                        rv_d = 1'b1;
                     end
                  end else begin
                     bit_d = bit_q + 4'h1;
                     sda_d = rx_q ? 1'b1 : sh_q[6];
                  end
               end else begin
                  bit_d = 4'h0;
                  if (!rx_q && sda_s_q[1]) begin
                     nk_d = 1'b1; sda_d = 1'b0; st_d = MST_STOP;
                  end else if (rx_q) begin
                     len_d = len_q - 4'h1;
                     sda_d = 1'b1; st_d = (len_q == 4'h1) ? MST_STOP : MST_BIT;
                     if (len_q == 4'h1) sda_d = 1'b0;
                  end else begin
                     byt_d = byt_q + 2'h1;
                     st_d = MST_BIT;
                     if (byt_q == 2'h0) begin
                        sh_d = ra_q; sda_d = ra_q[7];
                     end else if (rw_q && byt_q == 2'h1) begin
                        sda_d = 1'b1; st_d = MST_RSTRT;
                        sh_d = {ta_q, DIR_READ};
                     end else if (rw_q) begin
                        rx_d = 1'b1; sda_d = 1'b1;
                     end else if (byt_q == 2'h1) begin
                        sh_d = wd_q; sda_d = wd_q[7];
                     end else begin
                        sda_d = 1'b0; st_d = MST_STOP;
                     end
                  end
               end
            end
         end
         MST_STOP: if (tick) begin
            ph_d = ~ph_q;
            if (!ph_q) scl_d = 1'b1;
            else begin
               sda_d = 1'b1; st_d = MST_DONE;
            end
         end
         default: if (tick) st_d = MST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q <= MST_IDLE; tm_q <= 16'h0000; ph_q <= 1'b0;
         scl_q <= 1'b1; sda_q <= 1'b1; sh_q <= 8'h00; rd_q <= 8'h00;
         bit_q <= 4'h0; len_q <= 4'h0; byt_q <= 2'h0; rw_q <= 1'b0;
         rv_q <= 1'b0; nk_q <= 1'b0; rx_q <= 1'b0; ta_q <= 7'h00;
         ra_q <= 8'h00; wd_q <= 8'h00; sda_s_q <= 2'h3;
      end else begin
         st_q <= st_d; tm_q <= tm_d; ph_q <= ph_d;
         scl_q <= scl_d; sda_q <= sda_d; sh_q <= sh_d; rd_q <= rd_d;
         bit_q <= bit_d; len_q <= len_d; byt_q <= byt_d; rw_q <= rw_d;
         rv_q <= rv_d; nk_q <= nk_d; rx_q <= rx_d; ta_q <= ta_d;
         ra_q <= ra_d; wd_q <= wd_d; sda_s_q <= sda_s_d;
      end
   end

   assign bus.scl_oe_m = ~scl_q;
   assign bus.sda_oe_m = ~sda_q;
   assign busy_o   = (st_q != MST_IDLE);
   assign rdata_o  = rd_q;
   assign rvalid_o = rv_q;
   assign nack_o   = nk_q;
endmodule // acc_master
`default_nettype wire

/* File: rtl/acc_target.sv */
// Two-wire target port: register pointer, write and read of a register array.
// Assumes external pull-ups; mode pin high selects this port; straps stable.
`timescale 1ns/100ps
`default_nettype none
module acc_target #(
   parameter int DEPTH = acc_pkg::REG_DEPTH
) (
   input  wire logic sys_clk_i,
   input  wire logic rst_n_i,
   input  wire logic mode_sel_i,
   input  wire logic target_addr_select_i,
   acc_if.target     bus,
   output logic [7:0] wr_addr_o,
   output logic [7:0] wr_data_o,
   output logic       wr_stb_o
);
   import acc_pkg::*;
   // Array index width; accesses past DEPTH are guarded, not wrapped
   localparam int IDX_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   initial begin
      if (DEPTH < 1 || DEPTH > 256) $error("DEPTH out of range");
   end

   logic [2:0] scl_s_q, scl_s_d, sda_s_q, sda_s_d;
   logic [1:0] sel_s_q, sel_s_d, adr_s_q, adr_s_d;
   acc_tgt_state_e st_q, st_d;
   logic [7:0] sh_q, sh_d, ptr_q, ptr_d;
   logic [2:0] cnt_q, cnt_d;
   logic       dir_q, dir_d, first_q, first_d, oe_q, oe_d, go_q, go_d;
   logic [7:0] wa_q, wa_d, wd_q, wd_d;
   logic       ws_q, ws_d;
   logic [7:0] mem_q [DEPTH];

   logic scl_r, scl_f, sta, sto, sda_v, scl_v, en;
   logic [6:0] my_addr;
   logic [7:0] rd_byte;

   // Stages [0] only feed [1]; logic looks at [1] and [2]
   assign scl_v = scl_s_q[1];
   assign sda_v = sda_s_q[1];
   assign scl_r = scl_s_q[1] & ~scl_s_q[2];
   assign scl_f = ~scl_s_q[1] & scl_s_q[2];
   assign sta   = scl_v & scl_s_q[2] & ~sda_v & sda_s_q[2];
   assign sto   = scl_v & scl_s_q[2] & sda_v & ~sda_s_q[2];
   assign en    = sel_s_q[1];
   // address strap, synchronised like any pin
   assign my_addr = adr_s_q[1] ? ADDR_SEL_HIGH : ADDR_SEL_LOW;

   function automatic logic [7:0] rd_reg(input logic [7:0] a);
      rd_reg = (int'(a) < DEPTH) ? mem_q[a[IDX_W-1:0]] : 8'h00;
   endfunction

   assign rd_byte = rd_reg(ptr_q);

   always_comb begin
      // rate-free edge sampling of both lines
      scl_s_d = {scl_s_q[1:0], bus.scl};
      sda_s_d = {sda_s_q[1:0], bus.sda};
      sel_s_d = {sel_s_q[0], mode_sel_i};
      adr_s_d = {adr_s_q[0], target_addr_select_i};
      st_d    = st_q;
      sh_d    = sh_q;
      ptr_d   = ptr_q;
      cnt_d   = cnt_q;
      dir_d   = dir_q;
      first_d = first_q;
      oe_d    = oe_q;
      go_d    = go_q;
      wa_d    = wa_q;
      wd_d    = wd_q;
      ws_d    = 1'b0;
      if (!en || sto) begin
         st_d = TGT_IDLE;
         oe_d = 1'b0;
      end else if (sta) begin
         st_d = TGT_ADDR;
         cnt_d = BIT_MSB;
         oe_d = 1'b0;
         go_d = 1'b0;
      end else begin
         case (st_q)
            TGT_ADDR, TGT_RX: begin
               if (scl_r) begin
                  sh_d = {sh_q[6:0], sda_v};
                  cnt_d = cnt_q - 3'h1;
                  if (cnt_q == 3'h0) go_d = 1'b1;
               end
               if (scl_f && go_q) begin
                  go_d = 1'b0;
                  if (st_q == TGT_ADDR) begin
                     if (sh_q[7:1] == my_addr) begin
                        dir_d = sh_q[0];
                        first_d = 1'b1;
                        oe_d = 1'b1;
                        st_d = TGT_ACK;
                     end else begin
                        st_d = TGT_IDLE;
                     end
                  end else begin
                     oe_d = 1'b1;
                     st_d = TGT_ACK;
                     if (first_q) begin
                        ptr_d = sh_q;
                        first_d = 1'b0;
                     end else begin
                        wa_d = ptr_q;
                        wd_d = sh_q;
                        ws_d = 1'b1;
                        ptr_d = ptr_q + 8'h01;
                     end
                  end
               end
            end
            TGT_ACK: begin
               if (scl_f) begin
                  cnt_d = BIT_MSB;
                  if (dir_q == DIR_READ) begin
                     sh_d = rd_byte;
                     oe_d = ~rd_byte[7];
                     st_d = TGT_TX;
                  end else begin
                     oe_d = 1'b0;
                     st_d = TGT_RX;
                  end
               end
            end
            TGT_TX: begin
               if (scl_f) begin
                  if (cnt_q == 3'h0) begin
                     oe_d = 1'b0;
                     ptr_d = ptr_q + 8'h01;
                     st_d = TGT_MACK;
                  end else begin
                     cnt_d = cnt_q - 3'h1;
                     sh_d = {sh_q[6:0], 1'b0};
                     oe_d = ~sh_q[6];
                  end
               end
            end
            TGT_MACK: begin
               if (scl_r) go_d = sda_v;
               if (scl_f) begin
                  if (go_q) begin
                     st_d = TGT_IDLE;
                  end else begin
                     sh_d = rd_byte;
                     oe_d = ~rd_byte[7];
                     cnt_d = BIT_MSB;
                     st_d = TGT_TX;
                  end
                  go_d = 1'b0;
               end
            end
            default: oe_d = 1'b0;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         scl_s_q <= 3'h7;
         sda_s_q <= 3'h7;
         sel_s_q <= 2'h0;
         adr_s_q <= 2'h0;
         st_q    <= TGT_IDLE;
         sh_q    <= 8'h00;
         ptr_q   <= REG_PTR_RESET;
         cnt_q   <= 3'h0;
         dir_q   <= 1'b0;
         first_q <= 1'b0;
         oe_q    <= 1'b0;
         go_q    <= 1'b0;
         wa_q    <= 8'h00;
         wd_q    <= 8'h00;
         ws_q    <= 1'b0;
      end else begin
         scl_s_q <= scl_s_d;
         sda_s_q <= sda_s_d;
         sel_s_q <= sel_s_d;
         adr_s_q <= adr_s_d;
         st_q    <= st_d;
         sh_q    <= sh_d;
         ptr_q   <= ptr_d;
         cnt_q   <= cnt_d;
         dir_q   <= dir_d;
         first_q <= first_d;
         oe_q    <= oe_d;
         go_q    <= go_d;
         wa_q    <= wa_d;
         wd_q    <= wd_d;
         ws_q    <= ws_d;
      end
   end

   // Register array has no reset: contents come from writes only
   always_ff @(posedge sys_clk_i) begin
      if (ws_d && int'(ptr_q) < DEPTH) mem_q[ptr_q[IDX_W-1:0]] <= sh_q;
   end

   assign bus.sda_oe_t = oe_q;
   assign wr_addr_o = wa_q;
   assign wr_data_o = wd_q;
   assign wr_stb_o  = ws_q;
endmodule // acc_target
`default_nettype wire

/* File: test/acc_chk_assertions.sv */
// Checker for the two-wire link between the master and the target port.
// Assumes it watches the resolved lines of one link, with its own clock and reset.
`timescale 1ns/100ps
`default_nettype none
module acc_chk
   import acc_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic scl_oe_m,
   input wire logic sda_oe_m,
   input wire logic sda_oe_t,
   input wire logic scl,
   input wire logic sda
);
   logic       scl_q, sda_q, first_q, first_d, rise, start;
   logic [3:0] bit_q, bit_d;
   logic [7:0] sh_q, sh_d;

   // Bit position since the last start, and the first byte shifted in
   always_comb begin
      rise    = scl & ~scl_q;
      start   = scl & scl_q & sda_q & ~sda;
      bit_d   = bit_q;
      first_d = first_q;
      sh_d    = sh_q;
      if (start) begin
         bit_d   = 4'h0;
         first_d = 1'b1;
      end else if (rise) begin
         sh_d = {sh_q[6:0], sda};
         if (bit_q == 4'h8) begin
            bit_d   = 4'h0;
            first_d = 1'b0;
         end else begin
            bit_d = bit_q + 4'h1;
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         scl_q   <= 1'b1;
         sda_q   <= 1'b1;
         bit_q   <= 4'h0;
         first_q <= 1'b0;
         sh_q    <= 8'h00;
      end else begin
         scl_q   <= scl;
         sda_q   <= sda;
         bit_q   <= bit_d;
         first_q <= first_d;
         sh_q    <= sh_d;
      end
   end

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_stop;
      scl && $rose(sda);
   endsequence
   sequence s_hold_to_rise;
      sda_oe_t throughout (##[1:40] $rose(scl));
   endsequence

   chk_open_drain: assert property (sda_oe_t && scl |-> !sda_oe_m)
      else $error("target and master both drove data while clock high");
   chk_change_scl_low: assert property (!$stable(sda_oe_t) |-> !scl && !$past(scl))
      else $error("target data changed while clock high");
   chk_ack_hold: assert property ($rose(sda_oe_t) |-> s_hold_to_rise)
      else $error("target low bit not held to the clock rise");
   chk_start_quiet: assert property (scl && $past(scl) && $fell(sda) |-> !sda_oe_t)
      else $error("target driving at a start");
   chk_addr_listen: assert property (first_q && bit_q < 4'h8 |-> !sda_oe_t)
      else $error("target drove during the address byte");
   chk_addr_match: assert property (rise && first_q && bit_q == 4'h8 && sda_oe_t |->
      sh_q[7:1] == ADDR_SEL_HIGH || sh_q[7:1] == ADDR_SEL_LOW)
      else $error("target acked a foreign address");
   chk_stop_release: assert property (s_stop |=> !sda_oe_t [*8])
      else $error("target drove after a stop");
   chk_stop_idle: assert property (s_stop |=> (!scl_oe_m) [*8])
      else $error("clock dropped right after a stop");
endmodule // acc_chk
`default_nettype wire

/* File: test/testbench.sv */
// Bench joining the master and the target port over one link.
// Assumes a shortened bus clock half period of 16 system cycles.
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import acc_pkg::*;
   // mode pin and strap start high; the tests change both
   logic        sys_clk_i = 1'b0, rst_n_i = 1'b0, mode_sel_i = 1'b1;
   logic        target_addr_select_i = 1'b1, req_i = 1'b0, rd_i = 1'b0;
   logic [6:0]  taddr_i = 7'h00;
   logic [7:0]  reg_i = 8'h00, wdata_i = 8'h00, wr_addr_o, wr_data_o, rdata_o;
   logic [3:0]  len_i = 4'h1;
   logic        wr_stb_o, busy_o, rvalid_o, nack_o;
   logic [15:0] wq[$];
   logic [7:0]  rq[$];
   int          err_count = 0, n_tests = 0;

   acc_if link();
   acc_target #(.DEPTH(64)) acc_target_inst (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
      .mode_sel_i(mode_sel_i), .target_addr_select_i(target_addr_select_i),
      .bus(link.target), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o), .wr_stb_o(wr_stb_o));
   // bus traffic only, no sample stream
   acc_master #(.HALF(16)) acc_master_inst (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
      .bus(link.master), .req_i(req_i), .rd_i(rd_i), .taddr_i(taddr_i), .reg_i(reg_i),
      .wdata_i(wdata_i), .len_i(len_i), .busy_o(busy_o), .rdata_o(rdata_o),
      .rvalid_o(rvalid_o), .nack_o(nack_o));
   acc_chk acc_chk_inst (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .scl_oe_m(link.scl_oe_m),
      .sda_oe_m(link.sda_oe_m), .sda_oe_t(link.sda_oe_t), .scl(link.scl), .sda(link.sda));

   always #2 sys_clk_i = ~sys_clk_i;

   always @(posedge sys_clk_i) begin
      if (wr_stb_o === 1'b1) wq.push_back({wr_addr_o, wr_data_o});
      if (rvalid_o === 1'b1) rq.push_back(rdata_o);
   end

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", name, exp, got);
         err_count++;
      end
   endtask

   // One request; hold it until the master is busy, then wait for idle
   task automatic xfer(input logic rd, input logic [6:0] ta, input logic [7:0] rg,
                       input logic [7:0] wd, input logic [3:0] ln);
      int i;
      wq.delete();
      rq.delete();
      @(posedge sys_clk_i);
      #1;
      rd_i = rd; taddr_i = ta; reg_i = rg; wdata_i = wd; len_i = ln; req_i = 1'b1;
      for (i = 0; i < 100 && busy_o !== 1'b1; i++) begin
         @(posedge sys_clk_i);
         #1;
      end
      req_i = 1'b0;
      if (busy_o !== 1'b1) begin
         $display("wrong value busy expected 1 seen %b", busy_o);
         err_count++;
         complete_run();
      end
      for (i = 0; i < 20000 && busy_o !== 1'b0; i++) @(posedge sys_clk_i);
      if (i >= 20000) begin
         $display("wrong value busy expected 0 seen %b", busy_o);
         err_count++;
         complete_run();
      end
      repeat (20) @(posedge sys_clk_i);
   endtask

   task automatic t_address_select();
      logic ack;
      for (int s = 1; s >= 0; s--) begin
         for (int a = 0; a < 2; a++) begin
            ack = ((s == 1) == (a == 0));
            @(posedge sys_clk_i);
            #1;
            target_addr_select_i = s[0];
            xfer(1'b0, a ? ADDR_SEL_LOW : ADDR_SEL_HIGH, 8'h05 + 8'(a), 8'hA5 + 8'(a), 4'h1);
            check("nack", {15'h0000, ~ack}, {15'h0000, nack_o});
            check("write count", {15'h0000, ack}, 16'(wq.size()));
            if (ack) check("write", {8'h05 + 8'(a), 8'hA5 + 8'(a)}, wq[0]);
         end
      end
      $display("address select test done");
   endtask

   task automatic t_read_burst();
      xfer(1'b0, ADDR_SEL_LOW, 8'h3F, 8'hC3, 4'h1);
      check("edge write", 16'h3FC3, wq[0]);
      xfer(1'b1, ADDR_SEL_LOW, 8'h05, 8'h00, 4'h2);
      check("read count", 16'h0002, 16'(rq.size()));
      check("read first", 16'h00A5, {8'h00, rq[0]});
      check("read next", 16'h00A6, {8'h00, rq[1]});
      xfer(1'b1, ADDR_SEL_LOW, 8'h3F, 8'h00, 4'h2);
      check("read count top", 16'h0002, 16'(rq.size()));
      check("read top", 16'h00C3, {8'h00, rq[0]});
      check("read past", 16'h0000, {8'h00, rq[1]});
      xfer(1'b1, ADDR_SEL_LOW, 8'h06, 8'h00, 4'h1);
      check("single read", 16'h00A6, {8'h00, rq[0]});
      check("read nack", 16'h0000, {15'h0000, nack_o});
      $display("read burst test done");
   endtask

   task automatic t_mode_off();
      @(posedge sys_clk_i);
      #1;
      mode_sel_i = 1'b0;
      xfer(1'b0, ADDR_SEL_LOW, 8'h05, 8'h11, 4'h1);
      check("silent nack", 16'h0001, {15'h0000, nack_o});
      check("silent writes", 16'h0000, 16'(wq.size()));
      @(posedge sys_clk_i);
      #1;
      mode_sel_i = 1'b1;
      repeat (10) @(posedge sys_clk_i);
      xfer(1'b1, ADDR_SEL_LOW, 8'h05, 8'h00, 4'h1);
      check("kept value", 16'h00A5, {8'h00, rq[0]});
      $display("mode select test done");
   endtask

   initial begin
      repeat (10) @(posedge sys_clk_i);
      #1;
      rst_n_i = 1'b1;
      repeat (4) @(posedge sys_clk_i);
      t_address_select();
      t_read_burst();
      t_mode_off();
      complete_run();
   end
endmodule // testbench
`default_nettype wire
